// ---- rtl/iim_pkg.sv ----
package iim_pkg;
  // Frame layout
  localparam int          FRAME_BITS  = 16;
  localparam int          CODE_HI     = 15;
  localparam int          CODE_LO     = 14;
  localparam int          ADDR_HI     = 13;
  localparam int          ADDR_LO     = 9;
  localparam int          PAR_BIT     = 8;
  localparam logic [1:0]  WRITE_CODE  = 2'h1;
  // Register addresses
  localparam logic [4:0]  ADDR_TERM   = 5'h11;
  localparam logic [4:0]  ADDR_IRQ    = 5'h12;
  // Reset values
  localparam logic [7:0]  TERM_RESET  = 8'h00;
  localparam logic [7:0]  IRQ_RESET   = 8'h00;
  // Enable register bit positions
  localparam int          EN_BUS      = 7;
  localparam int          EN_REQ      = 6;
  localparam int          EN_LINK1    = 5;
  localparam int          EN_LINK0    = 4;
  localparam int          EN_WAKE     = 3;
  localparam int          EN_SAFE     = 2;
  localparam int          EN_UNUSED   = 1;
  localparam int          EN_VMON     = 0;
  localparam logic [7:0]  IRQ_WMASK   = 8'hFD;
  // Terminal codes
  localparam logic [1:0]  TERM_OFF    = 2'h0;
  localparam logic [1:0]  TERM_WAKE   = 2'h1;
  localparam logic [1:0]  TERM_LOW    = 2'h2;
  localparam logic [1:0]  TERM_HIGH   = 2'h3;
  localparam int          NUM_TERM    = 4;
  localparam int          NUM_LOWSIDE = 2;
  // Interrupt pulse timing
  localparam int          CLK_PERIOD_NS = 20;
  localparam int          INT_PULSE_NS  = 1000;
  localparam int          INT_PULSE_CYC = (INT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int          INT_GAP_CYC   = INT_PULSE_CYC;
  localparam int          CNT_W         = 8;
  // Interrupt sequencer states, Gray from idle through pulse to gap
  typedef enum logic [1:0] {
    ST_IDLE  = 2'h0,
    ST_PULSE = 2'h1,
    ST_GAP   = 2'h3
  } iim_int_state_e;
endpackage : iim_pkg

// ---- rtl/iim_frame_if.sv ----
`timescale 1ns/100ps
// Received frame handed from the serial receiver to the register core
interface iim_frame_if;
  logic        frame_vld;  // One-cycle pulse, frame complete
  logic [15:0] frame;      // Whole frame, first bit at 15
  modport rx   (output frame_vld, output frame);
  modport core (input frame_vld, input frame);
endinterface : iim_frame_if

// ---- rtl/iim_spi_rx.sv ----
`timescale 1ns/100ps
// Serial receiver: mode 0, MSB first, pins oversampled by sys_clk
module iim_spi_rx
  import iim_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Serial pins
  input  wire logic sclk,
  input  wire logic cs_n,
  input  wire logic mosi,
  // Frame out
  iim_frame_if.rx   fr
);
  logic [1:0]  sclk_sync_reg;  // Synchroniser chain
  logic [1:0]  cs_sync_reg;    // Synchroniser chain, idles high
  logic [1:0]  mosi_sync_reg;  // Synchroniser chain
  logic        sclk_d_reg;     // Previous synced clock
  logic        cs_d_reg;       // Previous synced select
  logic [15:0] shift_reg;      // Incoming bits
  logic [4:0]  cnt_reg;        // Bits seen, saturates
  logic        vld_reg;        // Frame pulse
  wire         sclk_rise = sclk_sync_reg[1] & ~sclk_d_reg;
  wire         cs_rise   = cs_sync_reg[1] & ~cs_d_reg;
  wire         active    = ~cs_sync_reg[1];
  wire         full_len  = (cnt_reg == 5'(FRAME_BITS));

  // Pins cross into sys_clk; first stage feeds only the second
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg   <= 2'h3;
      mosi_sync_reg <= 2'h0;
      sclk_d_reg    <= 1'b0;
      cs_d_reg      <= 1'b1;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk};
      cs_sync_reg   <= {cs_sync_reg[0], cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], mosi};
      sclk_d_reg    <= sclk_sync_reg[1];
      cs_d_reg      <= cs_sync_reg[1];
    end
  end

  // Shift on rising edge; counter restarts on every select
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_reg <= 16'h0000;
      cnt_reg   <= 5'h00;
    end else if (!active) begin
      cnt_reg   <= 5'h00;
    end else if (sclk_rise) begin
      shift_reg <= {shift_reg[14:0], mosi_sync_reg[1]};
      cnt_reg   <= (cnt_reg == 5'h1F) ? cnt_reg : cnt_reg + 5'h01;
    end
  end

  // Only exactly sixteen bits make a frame; others are dropped
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      vld_reg <= 1'b0;
    end else begin
      vld_reg <= cs_rise & full_len;
    end
  end

  assign fr.frame_vld = vld_reg;
  assign fr.frame     = shift_reg;
endmodule : iim_spi_rx

// ---- rtl/iim_regs.sv ----
`timescale 1ns/100ps
// Terminal configuration and interrupt enable registers with interrupt pulse
module iim_regs
  import iim_pkg::*;
#(
  parameter bit HAS_LINKS = 1'b1  // Zero for the variant without links
)
(
  // Clock and reset
  input  wire logic                sys_clk,
  input  wire logic                arst_n,
  // Serial pins
  input  wire logic                sclk,
  input  wire logic                cs_n,
  input  wire logic                mosi,
  // Event pulses from detectors, sys_clk domain
  input  wire logic                bus_fail_evt,
  input  wire logic                link0_fail_evt,
  input  wire logic                link1_fail_evt,
  input  wire logic [NUM_TERM-1:0] term_wake_evt,
  input  wire logic                safe_evt,
  input  wire logic                vmon_evt,
  // Terminal controls
  output logic      [NUM_TERM-1:0] term_lo_drv,
  output logic      [NUM_TERM-1:0] term_hi_drv,
  output logic      [NUM_TERM-1:0] term_wake_arm,
  // Register contents
  output logic      [7:0]          term_cfg,
  output logic      [7:0]          irq_en,
  // Interrupt line
  output logic                     int_n
);
  iim_frame_if fr ();

  // Serial receiver
  iim_spi_rx u_rx (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .sclk    (sclk),
    .cs_n    (cs_n),
    .mosi    (mosi),
    .fr      (fr)
  );

  logic [7:0]          term_reg;     // Terminal configuration
  logic [7:0]          irq_reg;      // Interrupt source enable
  logic [6:0]          pend_reg;     // Pending classes
  iim_int_state_e      state_reg;    // Interrupt sequencer
  iim_int_state_e      state_next;
  logic [CNT_W-1:0]    cnt_reg;      // Pulse and gap timer
  logic [CNT_W-1:0]    cnt_next;
  logic                int_n_reg;    // Interrupt line
  logic [NUM_TERM-1:0] lo_reg;       // Low side drivers
  logic [NUM_TERM-1:0] hi_reg;       // High side drivers
  logic [NUM_TERM-1:0] arm_reg;      // Wake-up armed
  logic [NUM_TERM-1:0] lo_next;
  logic [NUM_TERM-1:0] hi_next;
  logic [NUM_TERM-1:0] arm_next;

  // Frame decode: write code, good parity, known address
  wire       fr_write  = fr.frame[CODE_HI:CODE_LO] == WRITE_CODE;
  wire       fr_par_ok = ^fr.frame;
  wire [4:0] fr_addr   = fr.frame[ADDR_HI:ADDR_LO];
  wire [7:0] fr_data   = fr.frame[7:0];
  wire       wr_ok     = fr.frame_vld & fr_write & fr_par_ok;
  wire       wr_term   = wr_ok & (fr_addr == ADDR_TERM);
  wire       wr_irq    = wr_ok & (fr_addr == ADDR_IRQ);
  // Bit 1 never stored
  wire [7:0] irq_wdata = fr_data & IRQ_WMASK;
  // Host request fires on the write that sets bit 6
  wire       req_evt   = wr_irq & irq_wdata[EN_REQ] & ~irq_reg[EN_REQ];
  wire       link_on   = HAS_LINKS;

  // Events that pass their class enable; masked ones are lost
  wire       set_bus   = bus_fail_evt & irq_reg[EN_BUS];
  wire       set_link1 = link1_fail_evt & irq_reg[EN_LINK1] & link_on;
  wire       set_link0 = link0_fail_evt & irq_reg[EN_LINK0] & link_on;
  wire       set_wake  = |(term_wake_evt & arm_reg) & irq_reg[EN_WAKE];
  wire       set_safe  = safe_evt & irq_reg[EN_SAFE];
  wire       set_vmon  = vmon_evt & irq_reg[EN_VMON];
  wire [6:0] pend_set  = {set_bus, req_evt, set_link1, set_link0, set_wake, set_safe, set_vmon};
  // Sequencer takes every pending class as it starts a pulse
  wire       take      = (state_reg == ST_IDLE) & (|pend_reg);
  // Set wins over the take
  wire [6:0] pend_next = (take ? 7'h00 : pend_reg) | pend_set;

  // Register writes; power-on values are all zero
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      term_reg <= TERM_RESET;
      irq_reg  <= IRQ_RESET;
    end else begin
      if (wr_term) term_reg <= fr_data;
      if (wr_irq)  irq_reg  <= irq_wdata;
    end
  end

  // Per terminal decode; upper terminals have no low side
  for (genvar t = 0; t < NUM_TERM; t++) begin : g_term
    wire [1:0] code = term_reg[2*t+1:2*t];
    if (t < NUM_LOWSIDE) begin : g_full
      // Zero and one: low side on 10, high side on 11
      assign lo_next[t]  = code == TERM_LOW;
      assign hi_next[t]  = code == TERM_HIGH;
    end else begin : g_hi_only
      // Two and three: 10 and 11 both high side
      assign lo_next[t]  = 1'b0;
      assign hi_next[t]  = code[1];
    end
    assign arm_next[t] = code == TERM_WAKE;
  end

  // Driver controls come straight from flops
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      lo_reg  <= '0;
      hi_reg  <= '0;
      arm_reg <= '0;
    end else begin
      lo_reg  <= lo_next;
      hi_reg  <= hi_next;
      arm_reg <= arm_next;
    end
  end

  // Sequencer: one fixed low pulse, then a gap so pulses stay distinct
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    case (state_reg)
      ST_IDLE: begin
        // Any pending class starts a pulse
        if (take) begin
          state_next = ST_PULSE;
          cnt_next   = '0;
        end
      end
      ST_PULSE: begin
        if (cnt_reg == CNT_W'(INT_PULSE_CYC - 1)) begin
          state_next = ST_GAP;
          cnt_next   = '0;
        end else begin
          cnt_next   = cnt_reg + 1'b1;
        end
      end
      ST_GAP: begin
        // Events in the pulse or gap wait here as pending
        if (cnt_reg == CNT_W'(INT_GAP_CYC - 1)) begin
          state_next = ST_IDLE;
          cnt_next   = '0;
        end else begin
          cnt_next   = cnt_reg + 1'b1;
        end
      end
      default: begin
        state_next = ST_IDLE;
        cnt_next   = '0;
      end
    endcase
  end

  // Sequencer state, pending flags and line
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      cnt_reg   <= '0;
      pend_reg  <= 7'h00;
      int_n_reg <= 1'b1;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      pend_reg  <= pend_next;
      int_n_reg <= state_next != ST_PULSE;
    end
  end

  assign term_lo_drv   = lo_reg;
  assign term_hi_drv   = hi_reg;
  assign term_wake_arm = arm_reg;
  assign term_cfg      = term_reg;
  assign irq_en        = irq_reg;
  assign int_n         = int_n_reg;

  // Low cycles of the line, counted apart from the sequencer so the length check is independent
  logic [CNT_W-1:0] low_cnt_reg;  // Cycles the line has been low
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      low_cnt_reg <= '0;
    end else if (int_n_reg) begin
      low_cnt_reg <= '0;
    end else begin
      low_cnt_reg <= low_cnt_reg + 1'b1;
    end
  end

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_term_write_data: assert property (wr_term |=> term_cfg == $past(fr_data))
    else $error("terminal write not stored");
  a_bad_parity_drop: assert property (fr.frame_vld && !fr_par_ok |=> $stable(term_cfg) && $stable(irq_en))
    else $error("bad parity frame changed a register");
  a_t3_high_side: assert property (term_cfg[7] |=> term_hi_drv[3] && !term_lo_drv[3])
    else $error("terminal three high side not on");
  a_t2_wake_arm: assert property (term_cfg[5:4] == TERM_WAKE |=> term_wake_arm[2] && !term_hi_drv[2])
    else $error("terminal two wake not armed");
  a_t1_low_side: assert property (term_cfg[3:2] == TERM_LOW |=> term_lo_drv[1] && !term_hi_drv[1])
    else $error("terminal one low side not on");
  a_t0_off_code: assert property (term_cfg[1:0] == TERM_OFF |=> !term_lo_drv[0] && !term_hi_drv[0] &&
                                  !term_wake_arm[0])
    else $error("terminal zero not off");
  a_bus_masked: assert property (bus_fail_evt && !irq_en[EN_BUS] && !pend_reg[6] |=> !pend_reg[6])
    else $error("masked bus failure latched");
  a_req_once: assert property (wr_irq && irq_wdata[EN_REQ] && irq_reg[EN_REQ] && !pend_reg[5] |=> !pend_reg[5])
    else $error("host request repeated without new setting");
  a_req_fires: assert property (req_evt && state_reg == ST_IDLE |=> ##[1:2] !int_n)
    else $error("host request gave no interrupt");
  a_link_inert: assert property (!link_on |-> pend_reg[4:3] == 2'h0)
    else $error("link failure latched without links");
  a_unused_zero: assert property (irq_en[EN_UNUSED] == 1'b0)
    else $error("unused enable bit set");
  a_pulse_low: assert property (state_reg == ST_PULSE |-> !int_n)
    else $error("line high during pulse");
  a_pend_to_pulse: assert property (take |=> state_reg == ST_PULSE ##1 !int_n)
    else $error("pending class did not start pulse");
  a_pulse_length: assert property ($rose(int_n) |-> low_cnt_reg == CNT_W'(INT_PULSE_CYC))
    else $error("pulse length wrong");

  c_term_write: cover property (wr_term);
  c_req_pulse:  cover property (req_evt ##[1:3] !int_n);
  c_bus_irq:    cover property (set_bus ##[1:3] !int_n);
  c_back_pulse: cover property (state_reg == ST_GAP && |pend_set);
endmodule : iim_regs

// ---- testbench/iim_host_model.sv ----
`timescale 1ns/100ps
// Host stand-in: serial master, mode 0, MSB first, paced for the oversampler
module iim_host_model (
  // Clock
  input  wire logic sys_clk,
  // Serial pins
  output logic      sclk,
  output logic      cs_n,
  output logic      mosi
);
  localparam int PH = 4;  // Cycles per sclk phase, one above the three-cycle floor

  // Idle bus: clock low, not selected
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    mosi = 1'b0;
  end

  // Shift out the top nbits of f; short counts exist only to be refused
  task automatic send(input logic [15:0] f, input int nbits);
    @(negedge sys_clk);
    cs_n = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      mosi = f[15-i];  // Bit set well before the rise
      repeat (PH) @(negedge sys_clk);
      sclk = 1'b1;
      repeat (PH) @(negedge sys_clk);
      sclk = 1'b0;
    end
    repeat (PH) @(negedge sys_clk);
    cs_n = 1'b1;
    mosi = ~mosi;  // Released line shows no stale bit
    repeat (PH) @(negedge sys_clk);
  endtask : send
endmodule : iim_host_model

// ---- testbench/test_iim_regs.sv ----
`timescale 1ns/100ps
// Self-checking bench for the terminal and interrupt enable registers
module test_iim_regs;
  import iim_pkg::*;
  logic       sys_clk;      // 50 MHz
  logic       arst_n;       // Async reset
  logic       sclk;         // Serial clock from host
  logic       cs_n;         // Serial select from host
  logic       mosi;         // Serial data from host
  logic [5:0] ev;           // bus, link0, link1, wake, safe, vmon
  logic [3:0] lo_drv;       // Low side enables
  logic [3:0] hi_drv;       // High side enables
  logic [3:0] wake_arm;     // Wake armed flags
  logic [7:0] term_cfg;     // Terminal register
  logic [7:0] irq_en;       // Enable register
  logic       int_n;        // Interrupt line
  logic [7:0] irq_en_nl;    // Enable register, variant without links
  logic       int_nl_n;     // Interrupt line, variant without links
  int         num_errors;   // Mismatches
  int         comparisons;  // Checks made
  int         cycles;       // Timeout counter

  // Clock
  always #10 sys_clk = ~sys_clk;

  iim_host_model host (.sys_clk(sys_clk), .sclk(sclk), .cs_n(cs_n), .mosi(mosi));

  iim_regs uut (
    .sys_clk(sys_clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .bus_fail_evt(ev[0]), .link0_fail_evt(ev[1]), .link1_fail_evt(ev[2]),
    .term_wake_evt({4{ev[3]}}), .safe_evt(ev[4]), .vmon_evt(ev[5]),
    .term_lo_drv(lo_drv), .term_hi_drv(hi_drv), .term_wake_arm(wake_arm),
    .term_cfg(term_cfg), .irq_en(irq_en), .int_n(int_n)
  );

  // Variant without links, sharing every input
  iim_regs #(.HAS_LINKS(1'b0)) uut_nl (
    .sys_clk(sys_clk), .arst_n(arst_n), .sclk(sclk), .cs_n(cs_n), .mosi(mosi),
    .bus_fail_evt(ev[0]), .link0_fail_evt(ev[1]), .link1_fail_evt(ev[2]),
    .term_wake_evt({4{ev[3]}}), .safe_evt(ev[4]), .vmon_evt(ev[5]),
    .term_lo_drv(), .term_hi_drv(), .term_wake_arm(),
    .term_cfg(), .irq_en(irq_en_nl), .int_n(int_nl_n)
  );

  // Write frame with odd parity over all sixteen bits
  function automatic logic [15:0] frm(input logic [4:0] a, input logic [7:0] d);
    return {WRITE_CODE, a, ~^{WRITE_CODE, a, d}, d};
  endfunction : frm

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("FAIL at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic conclude;
    $display("Comparisons %0d, mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // Full write, then room for the store and driver update
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    host.send(frm(a, d), 16);
    repeat (8) @(negedge sys_clk);
  endtask : wr

  // One-cycle event pulse
  task automatic fire(input int k);
    @(negedge sys_clk);
    ev[k] = 1'b1;
    @(negedge sys_clk);
    ev = '0;
  endtask : fire

  // Look for a low on int_n, then let pulse and gap run out
  task automatic expect_int(input logic exp);
    logic low;
    low = 1'b0;
    repeat (12) begin
      @(negedge sys_clk);
      if (int_n === 1'b0) low = 1'b1;
    end
    check({7'h0, low}, {7'h0, exp});
    repeat (2 * INT_PULSE_CYC + 20) @(negedge sys_clk);
  endtask : expect_int

  task automatic t_reset;
    check(term_cfg, TERM_RESET);
    check({lo_drv, hi_drv}, 8'h00);
    check({4'h0, wake_arm}, 8'h00);
    check(irq_en, IRQ_RESET);
    check({7'h0, int_n}, 8'h01);
  endtask : t_reset

  // Every code on every terminal at once
  task automatic t_terminals;
    logic [1:0] c;
    logic [3:0] lo;
    logic [3:0] hi;
    for (int i = 0; i < 4; i++) begin
      c = i[1:0];
      wr(ADDR_TERM, {4{c}});
      lo = {2'b00, {2{c == TERM_LOW}}};
      hi = {{2{c[1]}}, {2{c == TERM_HIGH}}};
      check(term_cfg, {4{c}});
      check({lo_drv, hi_drv}, {lo, hi});
      check({4'h0, wake_arm}, {4'h0, {4{c == TERM_WAKE}}});
    end
  endtask : t_terminals

  // Malformed frames leave the stored 0xFF alone
  task automatic t_refused;
    host.send(frm(ADDR_TERM, 8'h00) ^ 16'h0100, 16);
    host.send({2'b10, ADDR_TERM, 1'b0, 8'h00}, 16);  // Good parity, only the code is wrong
    host.send(frm(5'h13, 8'h00), 16);
    host.send(frm(ADDR_TERM, 8'h00), 15);
    repeat (8) @(negedge sys_clk);
    check(term_cfg, 8'hFF);
  endtask : t_refused

  // Host request: one pulse of fixed length, none on a repeat write
  task automatic t_request;
    int n;
    n = 0;
    host.send(frm(ADDR_IRQ, 8'h40), 16);
    repeat (20) if (int_n !== 1'b0) @(negedge sys_clk);
    while (int_n === 1'b0 && n < 200) begin
      n++;
      @(negedge sys_clk);
    end
    check(n[7:0], INT_PULSE_CYC[7:0]);
    repeat (INT_GAP_CYC + 10) @(negedge sys_clk);
    wr(ADDR_IRQ, 8'hFF);
    expect_int(1'b0);
    check(irq_en, IRQ_WMASK);
    wr(ADDR_IRQ, 8'h00);
    expect_int(1'b0);
    wr(ADDR_IRQ, 8'h40);
    expect_int(1'b1);
  endtask : t_request

  // Each class alone: masked by its own bit only, passed by it alone
  task automatic t_classes;
    int bits [6] = '{EN_BUS, EN_LINK0, EN_LINK1, EN_WAKE, EN_SAFE, EN_VMON};
    wr(ADDR_TERM, 8'h55);
    for (int k = 0; k < 6; k++) begin
      fire(k);
      expect_int(1'b0);
    end
    wr(ADDR_IRQ, 8'hBD);
    expect_int(1'b0);
    for (int k = 0; k < 6; k++) begin
      wr(ADDR_IRQ, 8'hBD & ~(8'h01 << bits[k]));
      fire(k);
      expect_int(1'b0);
      wr(ADDR_IRQ, 8'h01 << bits[k]);
      fire(k);
      expect_int(1'b1);
    end
  endtask : t_classes

  // Variant without links: link enables stored but inert
  task automatic t_no_links;
    logic low;
    logic low_nl;
    wr(ADDR_IRQ, 8'h30);
    check(irq_en_nl, 8'h30);
    for (int k = 1; k < 3; k++) begin
      fire(k);
      low    = 1'b0;
      low_nl = 1'b0;
      repeat (12) begin
        @(negedge sys_clk);
        if (int_n === 1'b0) low = 1'b1;
        if (int_nl_n === 1'b0) low_nl = 1'b1;
      end
      check({6'h00, low, low_nl}, 8'h02);
      repeat (2 * INT_PULSE_CYC + 20) @(negedge sys_clk);
    end
  endtask : t_no_links

  // Mid-run reset clears registers that hold non-zero values
  task automatic t_rereset;
    wr(ADDR_TERM, 8'hA6);
    check(term_cfg, 8'hA6);
    arst_n = 1'b0;
    repeat (2) @(negedge sys_clk);
    arst_n = 1'b1;
    t_reset();
  endtask : t_rereset

  // Hang guard, well above the few dozen frames and interrupt waits' worth of cycles used
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      conclude();
    end
  end

  // Main sequence
  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    ev = '0;
    num_errors = 0;
    comparisons = 0;
    cycles = 0;
    repeat (16) @(negedge sys_clk);
    arst_n = 1'b1;
    t_reset();
    t_terminals();
    t_refused();
    t_request();
    t_classes();
    t_no_links();
    t_rereset();
    conclude();
  end
endmodule : test_iim_regs
